// File: src/fsr_pkg.sv
// package: register map, field layout and types for the flash security block
package fsr_pkg;
  localparam logic [15:0] FSR_ADDR_CLKDIV = 16'h1820;
  localparam logic [15:0] FSR_ADDR_OPTION = 16'h1821;
  localparam logic [15:0] FSR_ADDR_CONFIG = 16'h1823;
  localparam logic [15:0] FSR_ADDR_PROTECT = 16'h1824;
  localparam logic [15:0] FSR_ADDR_STATUS = 16'h1825;
  localparam logic [15:0] FSR_ADDR_COMMAND = 16'h1826;
  localparam logic [15:0] FSR_ADDR_KEY_BASE = 16'hffb0;
  localparam logic [15:0] FSR_ADDR_NV_PROTECT = 16'hffbd;
  localparam logic [15:0] FSR_ADDR_NV_OPTION = 16'hffbf;
  localparam logic [15:0] FSR_ADDR_SECSTAT = 16'h1827;
  localparam int FSR_KEY_BYTES = 8;
  localparam int FSR_KEY_IDX_BITS = 3;
  localparam int FSR_KEY_TOP_BIT = 63;
  localparam int FSR_BYTE_BITS = 8;
  localparam int FSR_OPT_KEY_ENABLE_BIT = 7;
  localparam int FSR_OPT_REDIRECT_OFF_BIT = 6;
  localparam int FSR_OPT_SEC_HIGH_BIT = 1;
  localparam int FSR_OPT_SEC_LOW_BIT = 0;
  localparam int FSR_CNFG_KEY_ACCESS_BIT = 5;
  localparam logic [1:0] FSR_SEC_UNSECURE = 2'h2;
  localparam logic [7:0] FSR_OPT_MASK = 8'hc3;
  localparam logic [7:0] FSR_CNFG_MASK = 8'h20;
  localparam logic [7:0] FSR_BYTE_ZERO = 8'h00;
  localparam logic [7:0] FSR_CLKDIV_RESET = 8'h00;
  localparam logic [7:0] FSR_COMMAND_RESET = 8'h00;
  localparam logic [7:0] FSR_STATUS_RESET = 8'hc0;
  localparam logic [7:0] FSR_STATUS_W1C = 8'h30;
  localparam int FSR_STATUS_BLANK_BIT = 2;
  localparam int FSR_CLKDIV_LOAD_BIT = 7;
  localparam int FSR_SECSTAT_SECURE_BIT = 0;

  typedef enum logic [2:0] {
    FSR_ST_LOAD = 3'h1,
    FSR_ST_SECURE = 3'h2,
    FSR_ST_OPEN = 3'h4
  } fsr_state_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } fsr_bus_t;

  typedef struct packed {
    logic from_secure;
    logic from_debug;
    logic is_ram;
    logic is_secure_flash;
    logic valid;
  } fsr_mem_req_t;

  typedef struct packed {
    fsr_state_t st;
    logic [7:0] opt;
    logic [7:0] prot;
    logic [7:0] cnfg;
    logic [7:0] clkdiv;
    logic [7:0] status;
    logic [7:0] command;
    logic [FSR_KEY_BYTES-1:0] key_ok;
    logic [FSR_KEY_BYTES-1:0] key_seen;
    logic erased;
    logic [7:0] rdata;
    logic grant;
    logic deny;
    logic secure;
  } fsr_regs_t;
endpackage

// File: src/fsr_flash_security.sv
// flash and ram security: option load, backdoor key, access gating
// ----------------------------------------------------------------
// limitations
// ----------------------------------------------------------------
// the ram array and the flash command sequencer live outside this block;
// only the gate in front of them and the status they report are kept here
//
// Design decision made here: strobed register access.
`timescale 1ns/100ps
module fsr_flash_security
  import fsr_pkg::*;
#(
  parameter int KEY_BYTES = FSR_KEY_BYTES
)(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [63:0] backdoor_key_store,
  input wire logic [7:0] nonvolatile_protect_image,
  input wire logic [7:0] nonvolatile_option_image,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_from_secure,
  input wire logic reg_from_debug,
  input wire logic mass_erase_done,
  input wire logic blank_verify_ok,
  input wire fsr_mem_req_t mem_req,
  output logic [7:0] reg_rdata,
  output logic mem_grant,
  output logic mem_deny,
  output logic secure_active
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  // the key index is a fixed slice of the address, so only eight bytes fit
  if (KEY_BYTES != FSR_KEY_BYTES)
  begin : g_bad_key
    $error("key length must be eight bytes");
  end

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  // reset asserts at once but leaves on a clock edge, so no register
  // sees the release in the middle of a cycle
  logic rst_meta_ff;
  logic rst_sync_ff;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  fsr_regs_t r_ff;
  fsr_regs_t nxt_r;
  fsr_bus_t bus;
  logic [7:0] key_byte [KEY_BYTES];
  logic key_hit;
  logic key_path_ok;
  logic key_unlock;
  logic erase_unlock;
  logic nv_unsec;
  logic sec_now;
  logic mem_blocked;

  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // ----------------------------------------------------------------
  // key bytes
  // ----------------------------------------------------------------
  // key byte 0 sits at the lowest flash address, most significant byte of the input
  for (genvar i = 0; i < KEY_BYTES; i++)
  begin : g_key
    assign key_byte[i] = backdoor_key_store[FSR_KEY_TOP_BIT-FSR_BYTE_BITS*i -: FSR_BYTE_BITS];
  end

  // ----------------------------------------------------------------
  // key path
  // ----------------------------------------------------------------
  // the key window covers the eight consecutive key store addresses
  assign key_hit = bus.wr &&
                   (bus.addr >= FSR_ADDR_KEY_BASE) &&
                   (bus.addr < FSR_ADDR_KEY_BASE + 16'(KEY_BYTES));

  // debug writes and non-secure code both fail this gate
  assign key_path_ok = r_ff.opt[FSR_OPT_KEY_ENABLE_BIT] &&
                       r_ff.cnfg[FSR_CNFG_KEY_ACCESS_BIT] &&
                       reg_from_secure &&
                       !reg_from_debug;

  // the enable bit is looked at again here, so a stale attempt can never open
  assign key_unlock = (&r_ff.key_seen) &&
                      (&r_ff.key_ok) &&
                      r_ff.opt[FSR_OPT_KEY_ENABLE_BIT];

  // ----------------------------------------------------------------
  // erase path
  // ----------------------------------------------------------------
  // the erase may be reported together with the blank verify or before it
  assign erase_unlock = (r_ff.erased || mass_erase_done) &&
                        blank_verify_ok;

  // ----------------------------------------------------------------
  // security decode
  // ----------------------------------------------------------------
  assign nv_unsec = (nonvolatile_option_image[FSR_OPT_SEC_HIGH_BIT:FSR_OPT_SEC_LOW_BIT] ==
                     FSR_SEC_UNSECURE);
  assign sec_now = (r_ff.st != FSR_ST_OPEN);

  // ram and secure flash are both secure resources
  assign mem_blocked = sec_now &&
                       (mem_req.is_ram || mem_req.is_secure_flash) &&
                       (mem_req.from_debug || !mem_req.from_secure);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [FSR_KEY_IDX_BITS-1:0] kidx;
    logic [7:0] rdv;
    nxt_r = r_ff;
    kidx = bus.addr[FSR_KEY_IDX_BITS-1:0];
    rdv = FSR_BYTE_ZERO;
    nxt_r.grant = 1'b0;
    nxt_r.deny = 1'b0;

    // security state
    case (r_ff.st)
      FSR_ST_LOAD:
      begin
        // first cycle after release: take nonvolatile images
        nxt_r.prot = nonvolatile_protect_image;
        nxt_r.opt = nonvolatile_option_image & FSR_OPT_MASK;
        nxt_r.key_ok = '0;
        nxt_r.key_seen = '0;
        nxt_r.erased = 1'b0;
        if (nv_unsec)
        begin
          nxt_r.st = FSR_ST_OPEN;
        end
        else
        begin
          nxt_r.st = FSR_ST_SECURE;
        end
      end
      FSR_ST_SECURE:
      begin
        // a byte only counts when it arrives over the trusted path
        if (key_hit && key_path_ok)
        begin
          nxt_r.key_seen[kidx] = 1'b1;
          nxt_r.key_ok[kidx] = (bus.wdata == key_byte[kidx]);
        end
        // all eight bytes in: a miss clears the attempt, a full match opens until reset
        if (&r_ff.key_seen)
        begin
          nxt_r.key_seen = '0;
          nxt_r.key_ok = '0;
          if (key_unlock)
          begin
            nxt_r.st = FSR_ST_OPEN;
          end
        end
        // the erase is remembered so a later blank verify can still open
        if (mass_erase_done)
        begin
          nxt_r.erased = 1'b1;
        end
        if (erase_unlock)
        begin
          nxt_r.st = FSR_ST_OPEN;
          nxt_r.status[FSR_STATUS_BLANK_BIT] = 1'b1;
        end
      end
      FSR_ST_OPEN:
      begin
        // stays open until the next reset reloads the option copy
        nxt_r.st = FSR_ST_OPEN;
      end
      default:
      begin
        // an illegal code falls back to the safe side
        nxt_r.st = FSR_ST_SECURE;
      end
    endcase
    nxt_r.secure = (nxt_r.st != FSR_ST_OPEN);

    // memory gate; ram contents are never touched here
    if (mem_req.valid)
    begin
      if (mem_blocked)
      begin
        nxt_r.deny = 1'b1;
      end
      else
      begin
        nxt_r.grant = 1'b1;
      end
    end

    // register writes; the load cycle owns the working copies
    if (bus.wr && (r_ff.st != FSR_ST_LOAD))
    begin
      case (bus.addr)
        FSR_ADDR_CLKDIV:
        begin
          // write-once divider: the load flag locks further writes
          if (!r_ff.clkdiv[FSR_CLKDIV_LOAD_BIT])
          begin
            nxt_r.clkdiv = {1'b1, bus.wdata[FSR_CLKDIV_LOAD_BIT-1:0]};
          end
        end
        FSR_ADDR_CONFIG:
        begin
          nxt_r.cnfg = bus.wdata & FSR_CNFG_MASK;
        end
        FSR_ADDR_PROTECT:
        begin
          nxt_r.prot = bus.wdata;
        end
        FSR_ADDR_STATUS:
        begin
          // clear from the next value so a flag set in this cycle survives
          nxt_r.status = nxt_r.status & ~(bus.wdata & FSR_STATUS_W1C);
        end
        FSR_ADDR_COMMAND:
        begin
          nxt_r.command = bus.wdata;
        end
        default:
        begin
          nxt_r.command = nxt_r.command;
        end
      endcase
    end

    // register reads, data one cycle later
    if (bus.rd)
    begin
      case (bus.addr)
        FSR_ADDR_CLKDIV: rdv = r_ff.clkdiv;
        FSR_ADDR_OPTION: rdv = r_ff.opt;
        FSR_ADDR_CONFIG: rdv = r_ff.cnfg;
        FSR_ADDR_PROTECT: rdv = r_ff.prot;
        FSR_ADDR_STATUS: rdv = r_ff.status;
        FSR_ADDR_COMMAND: rdv = r_ff.command;
        FSR_ADDR_NV_PROTECT: rdv = nonvolatile_protect_image;
        FSR_ADDR_NV_OPTION: rdv = nonvolatile_option_image;
        FSR_ADDR_SECSTAT: rdv[FSR_SECSTAT_SECURE_BIT] = sec_now;
        default: rdv = FSR_BYTE_ZERO;
      endcase
    end
    nxt_r.rdata = rdv;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // reset leaves the block secure; the load cycle, a full key match or an erase with blank verify may open it

  always_ff @(posedge clk or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      r_ff.st <= FSR_ST_LOAD;
      r_ff.opt <= FSR_BYTE_ZERO;
      r_ff.prot <= FSR_BYTE_ZERO;
      r_ff.cnfg <= FSR_BYTE_ZERO;
      r_ff.clkdiv <= FSR_CLKDIV_RESET;
      r_ff.status <= FSR_STATUS_RESET;
      r_ff.command <= FSR_COMMAND_RESET;
      r_ff.key_ok <= '0;
      r_ff.key_seen <= '0;
      r_ff.erased <= 1'b0;
      r_ff.rdata <= FSR_BYTE_ZERO;
      r_ff.grant <= 1'b0;
      r_ff.deny <= 1'b0;
      r_ff.secure <= 1'b1;
    end
    else
    begin
      r_ff <= nxt_r;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // every output is a field of the state register, never a decode
  assign reg_rdata = r_ff.rdata;
  assign mem_grant = r_ff.grant;
  assign mem_deny = r_ff.deny;
  assign secure_active = r_ff.secure;
endmodule

// File: bench/fsr_nv_model.sv
// model: nonvolatile flash area that feeds the security block
`timescale 1ns/100ps
module fsr_nv_model (
  input wire logic [63:0] key_cfg,
  input wire logic [7:0] prot_cfg,
  input wire logic [7:0] opt_cfg,
  output logic [63:0] backdoor_key_store,
  output logic [7:0] nonvolatile_protect_image,
  output logic [7:0] nonvolatile_option_image
);
  // programmed flash: images only change between resets
  assign backdoor_key_store = key_cfg;
  assign nonvolatile_protect_image = prot_cfg;
  assign nonvolatile_option_image = opt_cfg;
endmodule

// File: bench/fsr_monitor.sv
// checker: option load, unlock paths and access gating
`timescale 1ns/100ps
module fsr_chk
  import fsr_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] nonvolatile_option_image,
  input wire logic [15:0] reg_addr,
  input wire logic reg_rd,
  input wire logic mass_erase_done,
  input wire logic blank_verify_ok,
  input wire fsr_mem_req_t mem_req,
  input wire logic [7:0] reg_rdata,
  input wire logic mem_grant,
  input wire logic mem_deny,
  input wire logic secure_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire unsec = nonvolatile_option_image[1:0] == FSR_SEC_UNSECURE;
  wire key_allowed = nonvolatile_option_image[FSR_OPT_KEY_ENABLE_BIT];
  sequence s_bad;
    mem_req.valid && secure_active && (mem_req.is_ram || mem_req.is_secure_flash)
      && (mem_req.from_debug || !mem_req.from_secure);
  endsequence
  sequence s_erase;
    mass_erase_done && blank_verify_ok && !key_allowed;
  endsequence
  AST_DENY: assert property (s_bad |=> mem_deny && !mem_grant)
    else $error("blocked access not denied");
  AST_GRANT: assert property (mem_req.valid && !secure_active |=> mem_grant)
    else $error("open access not granted");
  AST_ERASE: assert property (s_erase |-> ##[1:3] !secure_active)
    else $error("erase and blank did not unlock");
  AST_FELL: assert property ($fell(secure_active) |-> unsec || key_allowed || $past(blank_verify_ok)
    || $past(blank_verify_ok, 2))
    else $error("unlock with key disabled");
  AST_ROSE: assert property (!$rose(secure_active))
    else $error("secure entered without reset");
  AST_LDSEC: assert property ($rose(rstn) && !unsec |-> secure_active[*6])
    else $error("secure image not applied");
  AST_LDOPEN: assert property ($rose(rstn) && unsec |-> ##[1:6] !secure_active)
    else $error("unsecure image not applied");
  AST_RDOPT: assert property (reg_rd && reg_addr == FSR_ADDR_OPTION
    |=> reg_rdata == (nonvolatile_option_image & FSR_OPT_MASK))
    else $error("option working copy wrong");
endmodule
bind fsr_flash_security fsr_chk i_chk (
  .clk(clk),
  .rstn(rstn),
  .nonvolatile_option_image(nonvolatile_option_image),
  .reg_addr(reg_addr),
  .reg_rd(reg_rd),
  .mass_erase_done(mass_erase_done),
  .blank_verify_ok(blank_verify_ok),
  .mem_req(mem_req),
  .reg_rdata(reg_rdata),
  .mem_grant(mem_grant),
  .mem_deny(mem_deny),
  .secure_active(secure_active)
);

// File: bench/test_flash_security_ram_access.sv
// testbench: security load, key and erase unlock, access gating
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; $display("CHECK FAILED %0t mismatch", $time); end end
module test_flash_security_ram_access
  import fsr_pkg::*;
;
  logic clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, reg_from_secure = 1'b0;
  logic reg_from_debug = 1'b0, mass_erase_done = 1'b0, blank_verify_ok = 1'b0;
  logic mem_grant, mem_deny, secure_active;
  logic [63:0] key_cfg = 64'h0, bks;
  logic [7:0] prot_cfg = 8'h00, opt_cfg = 8'h80, reg_wdata = 8'h00, reg_rdata, nvp, nvo;
  logic [15:0] reg_addr = 16'h0;
  logic [2:0] f;
  fsr_mem_req_t mem_req = '0;
  int mismatches = 0, compares = 0;
  always #2.5 clk = ~clk;
  fsr_nv_model i_nv (.key_cfg(key_cfg), .prot_cfg(prot_cfg), .opt_cfg(opt_cfg),
    .backdoor_key_store(bks), .nonvolatile_protect_image(nvp), .nonvolatile_option_image(nvo));
  fsr_flash_security i_dut (.clk(clk), .rstn(rstn), .backdoor_key_store(bks),
    .nonvolatile_protect_image(nvp), .nonvolatile_option_image(nvo), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_from_secure(reg_from_secure),
    .reg_from_debug(reg_from_debug), .mass_erase_done(mass_erase_done),
    .blank_verify_ok(blank_verify_ok), .mem_req(mem_req), .reg_rdata(reg_rdata),
    .mem_grant(mem_grant), .mem_deny(mem_deny), .secure_active(secure_active));
  function automatic logic want_deny(input logic [2:0] r, input logic s);
    return s & (~r[2] | r[1]);
  endfunction
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic do_reset(input logic [7:0] o);
    opt_cfg <= o;
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  // src is {from_secure, from_debug}
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] src);
    reg_addr <= a;
    reg_wdata <= d;
    {reg_from_secure, reg_from_debug} <= src;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
    @(posedge clk);
  endtask
  task automatic key_in(input logic [63:0] k, input logic [1:0] src);
    wr(FSR_ADDR_CONFIG, FSR_CNFG_MASK, 2'b10);
    for (int i = 0; i < FSR_KEY_BYTES; i++)
      wr(FSR_ADDR_KEY_BASE + 16'(i), k[63 - 8 * i -: 8], src);
    repeat (3) @(posedge clk);
  endtask
  task automatic mem(input logic [2:0] r, input logic d);
    mem_req <= '{from_secure: r[2], from_debug: r[1], is_ram: r[0], is_secure_flash: ~r[0], valid: 1'b1};
    @(posedge clk);
    mem_req.valid <= 1'b0;
    #1 `CHK({mem_grant, mem_deny}, {~d, d})
    @(posedge clk);
  endtask
  task automatic wait_sec(input logic e);
    for (int n = 0; n < 8 && secure_active !== e; n++)
      @(posedge clk) #1;
    `CHK(secure_active, e)
  endtask
  initial
  begin
    void'($urandom(32'h17fe324e));
    key_cfg <= {$urandom, $urandom};
    prot_cfg <= 8'($urandom);
    do_reset(8'h80);
    rd(FSR_ADDR_OPTION, 8'h80);
    rd(FSR_ADDR_PROTECT, prot_cfg);
    rd(16'h1822, FSR_BYTE_ZERO);
    rd(FSR_ADDR_SECSTAT, 8'h01);
    wr(FSR_ADDR_CLKDIV, 8'h13, 2'b10);
    wr(FSR_ADDR_CLKDIV, 8'h05, 2'b10);
    rd(FSR_ADDR_CLKDIV, 8'h93);
    repeat (8)
    begin
      f = 3'($urandom);
      mem(f, want_deny(f, 1'b1));
    end
    key_in(key_cfg, 2'b01);
    wait_sec(1'b1);
    key_in(key_cfg, 2'b00);
    wait_sec(1'b1);
    key_in(key_cfg ^ 64'h1, 2'b10);
    wait_sec(1'b1);
    key_in(key_cfg, 2'b10);
    wait_sec(1'b0);
    mem(3'b011, want_deny(3'b011, 1'b0));
    do_reset(8'h80);
    wait_sec(1'b1);
    do_reset(8'h00);
    key_in(key_cfg, 2'b10);
    wait_sec(1'b1);
    mass_erase_done <= 1'b1;
    blank_verify_ok <= 1'b1;
    @(posedge clk);
    {mass_erase_done, blank_verify_ok} <= 2'b00;
    wait_sec(1'b0);
    rd(FSR_ADDR_STATUS, 8'hc4);
    rd(FSR_ADDR_SECSTAT, 8'h00);
    do_reset(8'h02);
    wait_sec(1'b0);
    close_out();
  end
endmodule
